// *** mfmc_pkg.sv ***
// Constants, field positions and carrier types for the MAC frame mode control slice.
// Assumes one core clock, a synchronous active-high reset, and byte streams already on that clock.
// Contract
// - Bit 16 qualifies how one write updates mode bits 17 to 23.
// - Pass-FCS bit 17 copies the received FCS into the host buffer unchanged.
// - A frame not fitting the host buffer reports a buffer overflow.
// - FCS is withheld from frames that had their VLAN header removed.
// - Pass-bad-frame bit 18 delivers errored frames and flags their errors.
// - Transmit FCS bit 19 computes and appends an FCS to every frame.
// - With bit 19 clear, host bytes go out as the whole frame.
// - Wake enable bit 21 watches received frames and raises a wake request.
// - Group accept clear honours wake sequences only to the station address.
// - Group accept set adds hashed multicast and broadcast destinations.
// - VLAN strip bit 27 removes the VLAN header from received frames.
// - Oversize frames without acceptance are flagged when passed, else discarded.

package mfmc_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_STA_LO = 8'h04;
  localparam logic [7:0] A_STA_HI = 8'h08;
  localparam logic [7:0] A_HASH_LO = 8'h0c;
  localparam logic [7:0] A_HASH_HI = 8'h10;
  localparam logic [7:0] A_BUF_SIZE = 8'h14;
  localparam logic [7:0] A_INT_STAT = 8'h18;
  localparam logic [7:0] A_INT_MASK = 8'h1c;
  localparam logic [7:0] A_FRAME_STAT = 8'h20;

  // ------------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------------
  localparam int B_OVERSIZE_ACC = 15;
  localparam int B_QUAL_LO = 16;
  localparam int B_PASS_FCS = 17;
  localparam int B_PASS_BAD = 18;
  localparam int B_TX_FCS = 19;
  localparam int B_UNUSED = 20;
  localparam int B_WAKE_EN = 21;
  localparam int B_WAKE_GRP = 22;
  localparam int G_LO_LSB = 17;
  localparam int G_LO_MSB = 23;
  localparam int B_QUAL_HI = 24;
  localparam int B_VLAN_EN = 25;
  localparam int B_VLAN_STRIP = 27;
  localparam int G_HI_LSB = 25;
  localparam int G_HI_MSB = 31;
  localparam logic [31:0] MODE_RESET = 32'h0088_4000;

  // ------------------------------------------------------------------
  // Interrupt bits
  // ------------------------------------------------------------------
  localparam int INT_W = 5;
  localparam int I_RX_DONE = 0;
  localparam int I_RX_BAD = 1;
  localparam int I_RX_OVF = 2;
  localparam int I_TX_DONE = 3;
  localparam int I_WAKE = 4;

  // ------------------------------------------------------------------
  // Frame constants
  // ------------------------------------------------------------------
  localparam logic [15:0] MAX_FRAME = 16'h05ee;
  localparam logic [15:0] MAX_FRAME_VLAN = 16'h05f2;
  localparam logic [15:0] BUF_RESET = 16'h0600;
  localparam logic [15:0] VLAN_TPID = 16'h8100;
  localparam logic [15:0] TAG_HI_IDX = 16'h000c;
  localparam logic [15:0] TAG_LO_IDX = 16'h000d;
  localparam logic [15:0] TAG_LAST_IDX = 16'h000f;
  localparam logic [15:0] DST_LEN = 16'h0006;
  localparam logic [15:0] FCS_LEN = 16'h0004;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] POS_LAST = 3'h5;
  localparam logic [3:0] REP_LAST = 4'hf;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_RECV = 3'b001,
    RX_FLUSH = 3'b010,
    RX_STAT = 3'b100
  } mfmc_rx_e;

  typedef enum logic [1:0] {
    TX_DATA = 2'b01,
    TX_FCS = 2'b10
  } mfmc_tx_e;

  typedef struct packed {
    logic [15:0] length;
    logic crc_err;
    logic media_err;
    logic oversize;
    logic error;
    logic overflow;
    logic fcs_passed;
    logic vlan_stripped;
    logic discard;
  } mfmc_rx_stat_s;

endpackage : mfmc_pkg

// *** mfmc_crc32.sv ***
// Byte-wide reflected CRC-32 accumulator with a registered result.
// Assumes bytes arrive least significant bit first, as on the Ethernet medium.
`timescale 1ns/1ps

module mfmc_crc32 (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  import mfmc_pkg::*;

  logic [31:0] crc_nxt;

  always_comb begin
    crc_nxt = crc ^ {24'h00_0000, data};
    for (int i = 0; i < 8; i++) begin
      crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ CRC_POLY) : (crc_nxt >> 1);
    end
  end

  // Clear wins over a byte so a new frame always starts from the seed.
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= crc_nxt;
    end
  end

endmodule : mfmc_crc32

// *** mfmc_wake_detect.sv ***
// Detects the wake sequence in a received byte stream: six sync bytes, then the station address sixteen times.
// Assumes the caller clears it between frames and qualifies the hit with address acceptance.
`timescale 1ns/1ps

module mfmc_wake_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic valid,
  input wire logic [7:0] data,
  input wire logic [47:0] station,
  output logic hit
);
  import mfmc_pkg::*;

  logic [2:0] sync_r;
  logic [2:0] pos_r;
  logic [3:0] rep_r;
  logic in_addr_r;
  logic [7:0] want;

  assign want = in_addr_r ? station[8 * (5 - pos_r) +: 8] : station[47:40];

  always_ff @(posedge clk) begin
    hit <= 1'b0;
    if (rst || clear) begin
      sync_r <= 3'h0;
      pos_r <= 3'h0;
      rep_r <= 4'h0;
      in_addr_r <= 1'b0;
    end else if (valid) begin
      if (in_addr_r) begin
        if (data == want) begin
          pos_r <= (pos_r == POS_LAST) ? 3'h0 : pos_r + 3'h1;
          if (pos_r == POS_LAST) begin
            rep_r <= rep_r + 4'h1;
            if (rep_r == REP_LAST) begin
              hit <= 1'b1;
              in_addr_r <= 1'b0;
            end
          end
        end else begin
          // A broken copy restarts the search; an 0xff may already begin a new sync run.
          in_addr_r <= 1'b0;
          sync_r <= (data == SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end else if (data == SYNC_BYTE && sync_r != SYNC_LEN) begin
        sync_r <= sync_r + 3'h1;
      end else if (sync_r == SYNC_LEN && data == want) begin
        in_addr_r <= 1'b1;
        pos_r <= 3'h1;
        rep_r <= 4'h0;
        sync_r <= 3'h0;
      end else if (data != SYNC_BYTE) begin
        sync_r <= 3'h0;
      end
    end
  end

endmodule : mfmc_wake_detect

// *** mfmc_top.sv ***
// Mode control slice of the MAC: mode register, receive FCS and error handling, transmit FCS, wake detection.
// Assumes receive and transmit byte streams on the core clock and at least five idle cycles between
// received frames, which covers the FCS flush and the status cycle.
`timescale 1ns/1ps

module mfmc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_err,
  output logic rxh_valid,
  output logic [7:0] rxh_data,
  output logic rxh_last,
  output logic rxh_stat_valid,
  output mfmc_pkg::mfmc_rx_stat_s rxh_stat,
  input wire logic txh_valid,
  input wire logic [7:0] txh_data,
  input wire logic txh_last,
  output logic txh_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic wake_req,
  output logic irq
);
  import mfmc_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [47:0] sta_r;
  logic [63:0] hash_r;
  logic [15:0] buf_size_r;
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_stat_nxt;
  logic [INT_W-1:0] int_mask_r;
  logic [INT_W-1:0] events;
  logic wr_mode;
  logic wr_int_stat;

  mfmc_rx_e rx_state_r;
  logic [15:0] rx_cnt_r;
  logic [15:0] out_idx;
  logic [3:0][7:0] line_r;
  logic [1:0] flush_cnt_r;
  logic [15:0] dlv_r;
  logic [7:0] tag_hi_r;
  logic [47:0] dst_r;
  logic vlan_cut_r;
  logic media_err_r;
  logic oversize_r;
  logic overflow_r;
  logic fcs_pass_r;
  logic addr_ok_r;
  logic byte_in;
  logic drop_tag;
  logic emit;
  logic emit_last;
  logic room;
  logic do_flush;
  logic [15:0] max_len;
  logic [31:0] rx_crc;
  logic crc_bad;
  logic frame_err;
  logic stat_fire;
  logic grp_hit;
  logic uni_hit;
  logic wake_hit;
  logic wake_fire;

  mfmc_tx_e tx_state_r;
  logic [1:0] tx_fcs_cnt_r;
  logic [31:0] tx_crc;
  logic tx_take;
  logic tx_crc_clear;
  logic tx_end;

  // ------------------------------------------------------------------
  // Mode register write
  // ------------------------------------------------------------------
  assign wr_mode = reg_wr && reg_addr == A_MODE;

  // Qualifier bits and the unused bit are not stored, so they always read zero.
  always_comb begin
    mode_nxt = mode_r;
    mode_nxt[B_OVERSIZE_ACC:0] = reg_wdata[B_OVERSIZE_ACC:0];
    if (reg_wdata[B_QUAL_LO]) begin
      mode_nxt[G_LO_MSB:G_LO_LSB] = mode_r[G_LO_MSB:G_LO_LSB] | reg_wdata[G_LO_MSB:G_LO_LSB];
    end else begin
      mode_nxt[G_LO_MSB:G_LO_LSB] = mode_r[G_LO_MSB:G_LO_LSB] & ~reg_wdata[G_LO_MSB:G_LO_LSB];
    end
    if (reg_wdata[B_QUAL_HI]) begin
      mode_nxt[G_HI_MSB:G_HI_LSB] = mode_r[G_HI_MSB:G_HI_LSB] | reg_wdata[G_HI_MSB:G_HI_LSB];
    end else begin
      mode_nxt[G_HI_MSB:G_HI_LSB] = mode_r[G_HI_MSB:G_HI_LSB] & ~reg_wdata[G_HI_MSB:G_HI_LSB];
    end
    mode_nxt[B_QUAL_LO] = 1'b0;
    mode_nxt[B_QUAL_HI] = 1'b0;
    mode_nxt[B_UNUSED] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= mode_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Address, hash, buffer size and interrupt mask registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sta_r <= 48'h0000_0000_0000;
      hash_r <= 64'h0000_0000_0000_0000;
      buf_size_r <= BUF_RESET;
      int_mask_r <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        A_STA_LO: sta_r[31:0] <= reg_wdata;
        A_STA_HI: sta_r[47:32] <= reg_wdata[15:0];
        A_HASH_LO: hash_r[31:0] <= reg_wdata;
        A_HASH_HI: hash_r[63:32] <= reg_wdata;
        A_BUF_SIZE: buf_size_r <= reg_wdata[15:0];
        A_INT_MASK: int_mask_r <= reg_wdata[INT_W-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  assign wr_int_stat = reg_wr && reg_addr == A_INT_STAT;

  // A new event in the cycle of its write-one-to-clear keeps the bit set.
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (wr_int_stat) begin
      int_stat_nxt = int_stat_nxt & ~reg_wdata[INT_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_stat_r <= '0;
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq <= |(int_stat_nxt & int_mask_r);
      wake_req <= int_stat_nxt[I_WAKE];
    end
  end

  // ------------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    reg_rdata <= 32'h0000_0000;
    if (!rst && reg_rd) begin
      unique case (reg_addr)
        A_MODE: reg_rdata <= mode_r;
        A_STA_LO: reg_rdata <= sta_r[31:0];
        A_STA_HI: reg_rdata <= {16'h0000, sta_r[47:32]};
        A_HASH_LO: reg_rdata <= hash_r[31:0];
        A_HASH_HI: reg_rdata <= hash_r[63:32];
        A_BUF_SIZE: reg_rdata <= {16'h0000, buf_size_r};
        A_INT_STAT: reg_rdata <= {{(32 - INT_W){1'b0}}, int_stat_r};
        A_INT_MASK: reg_rdata <= {{(32 - INT_W){1'b0}}, int_mask_r};
        A_FRAME_STAT: reg_rdata <= {8'h00, rxh_stat};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Receive framing
  // ------------------------------------------------------------------
  // Bytes leave through a four-byte delay line, so the FCS is still inside it when the last byte lands.
  assign byte_in = rx_valid && rx_state_r == RX_RECV;
  assign out_idx = rx_cnt_r - FCS_LEN;
  assign drop_tag = vlan_cut_r && out_idx >= TAG_HI_IDX && out_idx <= TAG_LAST_IDX;
  assign do_flush = mode_r[B_PASS_FCS] && !vlan_cut_r;
  assign emit = (byte_in && rx_cnt_r >= FCS_LEN && !drop_tag) || rx_state_r == RX_FLUSH;
  assign emit_last = (byte_in && rx_last && !do_flush) || (rx_state_r == RX_FLUSH && flush_cnt_r == FCS_LAST);
  assign room = dlv_r < buf_size_r;
  assign max_len = mode_r[B_VLAN_EN] ? MAX_FRAME_VLAN : MAX_FRAME;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state_r <= RX_RECV;
      flush_cnt_r <= 2'h0;
    end else begin
      unique case (rx_state_r)
        RX_RECV: begin
          if (byte_in && rx_last) begin
            rx_state_r <= do_flush ? RX_FLUSH : RX_STAT;
            flush_cnt_r <= 2'h0;
          end
        end
        RX_FLUSH: begin
          flush_cnt_r <= flush_cnt_r + 2'h1;
          if (flush_cnt_r == FCS_LAST) begin
            rx_state_r <= RX_STAT;
          end
        end
        RX_STAT: rx_state_r <= RX_RECV;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || rx_state_r == RX_STAT) begin
      rx_cnt_r <= 16'h0000;
      vlan_cut_r <= 1'b0;
      tag_hi_r <= 8'h00;
      dst_r <= 48'h0000_0000_0000;
    end else if (byte_in) begin
      if (rx_cnt_r != 16'hffff) begin
        rx_cnt_r <= rx_cnt_r + 16'h0001;
      end
      if (rx_cnt_r < DST_LEN) begin
        dst_r <= {dst_r[39:0], rx_data};
      end
      if (rx_cnt_r == TAG_HI_IDX) begin
        tag_hi_r <= rx_data;
      end
      if (rx_cnt_r == TAG_LO_IDX) begin
        vlan_cut_r <= mode_r[B_VLAN_STRIP] && {tag_hi_r, rx_data} == VLAN_TPID;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      line_r <= '0;
    end else if (byte_in) begin
      line_r <= {line_r[2:0], rx_data};
    end else if (rx_state_r == RX_FLUSH) begin
      line_r <= {line_r[2:0], 8'h00};
    end
  end

  // ------------------------------------------------------------------
  // Host receive buffer side
  // ------------------------------------------------------------------
  // Once the buffer is full the rest of the frame is dropped; the end marker is then never sent.
  always_ff @(posedge clk) begin
    rxh_valid <= 1'b0;
    rxh_last <= 1'b0;
    if (rst) begin
      rxh_data <= 8'h00;
    end else if (emit && room) begin
      rxh_valid <= 1'b1;
      rxh_data <= line_r[3];
      rxh_last <= emit_last;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || rx_state_r == RX_STAT) begin
      dlv_r <= 16'h0000;
      overflow_r <= 1'b0;
    end else if (emit) begin
      if (room) begin
        dlv_r <= dlv_r + 16'h0001;
      end else begin
        overflow_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || rx_state_r == RX_STAT) begin
      media_err_r <= 1'b0;
      oversize_r <= 1'b0;
      fcs_pass_r <= 1'b0;
    end else if (byte_in) begin
      media_err_r <= media_err_r | rx_err;
      if (rx_last) begin
        oversize_r <= rx_cnt_r >= max_len;
        fcs_pass_r <= do_flush;
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive status
  // ------------------------------------------------------------------
  assign crc_bad = rx_crc != CRC_RESIDUE;
  assign frame_err = crc_bad || media_err_r || (oversize_r && !mode_r[B_OVERSIZE_ACC]);
  assign stat_fire = rx_state_r == RX_STAT;

  always_ff @(posedge clk) begin
    rxh_stat_valid <= 1'b0;
    if (rst) begin
      rxh_stat <= '0;
    end else if (stat_fire) begin
      rxh_stat_valid <= 1'b1;
      rxh_stat.length <= dlv_r;
      rxh_stat.crc_err <= crc_bad;
      rxh_stat.media_err <= media_err_r;
      rxh_stat.oversize <= oversize_r;
      rxh_stat.error <= frame_err;
      rxh_stat.overflow <= overflow_r;
      rxh_stat.fcs_passed <= fcs_pass_r;
      rxh_stat.vlan_stripped <= vlan_cut_r;
      rxh_stat.discard <= frame_err && !mode_r[B_PASS_BAD];
    end
  end

  mfmc_crc32 u_rx_crc (
    .clk(clk),
    .rst(rst),
    .clear(stat_fire),
    .en(byte_in),
    .data(rx_data),
    .crc(rx_crc)
  );

  // ------------------------------------------------------------------
  // Wake frame recognition
  // ------------------------------------------------------------------
  // The hash index is taken from the running FCS over the six destination bytes.
  assign uni_hit = dst_r == sta_r;
  assign grp_hit = &dst_r || (dst_r[40] && hash_r[rx_crc[5:0]]);

  always_ff @(posedge clk) begin
    if (rst || stat_fire) begin
      addr_ok_r <= 1'b0;
    end else if (byte_in && rx_cnt_r == DST_LEN) begin
      addr_ok_r <= uni_hit || (mode_r[B_WAKE_GRP] && grp_hit);
    end
  end

  mfmc_wake_detect u_wake (
    .clk(clk),
    .rst(rst),
    .clear(stat_fire),
    .valid(byte_in),
    .data(rx_data),
    .station(sta_r),
    .hit(wake_hit)
  );

  assign wake_fire = wake_hit && addr_ok_r && mode_r[B_WAKE_EN];

  // ------------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------------
  // Software is trusted to leave insertion features off when the FCS is not appended.
  assign tx_take = txh_valid && txh_ready && tx_state_r == TX_DATA;
  assign tx_end = tx_state_r == TX_FCS && tx_fcs_cnt_r == FCS_LAST;
  assign tx_crc_clear = tx_end || (tx_take && txh_last && !mode_r[B_TX_FCS]);

  always_ff @(posedge clk) begin
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    if (rst) begin
      tx_state_r <= TX_DATA;
      tx_fcs_cnt_r <= 2'h0;
      txh_ready <= 1'b1;
      tx_data <= 8'h00;
    end else begin
      unique case (tx_state_r)
        TX_DATA: begin
          if (tx_take) begin
            tx_valid <= 1'b1;
            tx_data <= txh_data;
            tx_last <= txh_last && !mode_r[B_TX_FCS];
            if (txh_last && mode_r[B_TX_FCS]) begin
              tx_state_r <= TX_FCS;
              tx_fcs_cnt_r <= 2'h0;
              txh_ready <= 1'b0;
            end
          end
        end
        TX_FCS: begin
          tx_valid <= 1'b1;
          tx_data <= ~tx_crc[{tx_fcs_cnt_r, 3'b000} +: 8];
          tx_last <= tx_fcs_cnt_r == FCS_LAST;
          tx_fcs_cnt_r <= tx_fcs_cnt_r + 2'h1;
          if (tx_fcs_cnt_r == FCS_LAST) begin
            tx_state_r <= TX_DATA;
            txh_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  mfmc_crc32 u_tx_crc (
    .clk(clk),
    .rst(rst),
    .clear(tx_crc_clear),
    .en(tx_take),
    .data(txh_data),
    .crc(tx_crc)
  );

  // ------------------------------------------------------------------
  // Event collection
  // ------------------------------------------------------------------
  always_comb begin
    events = '0;
    events[I_RX_DONE] = stat_fire;
    events[I_RX_BAD] = stat_fire && frame_err;
    events[I_RX_OVF] = stat_fire && overflow_r;
    events[I_TX_DONE] = tx_end || (tx_take && txh_last && !mode_r[B_TX_FCS]);
    events[I_WAKE] = wake_fire;
  end

endmodule : mfmc_top

// *** mfmc_props.sv ***
// Checker for the mode control slice, bound into every mfmc_top.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/1ps
module mfmc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rxh_last,
  input wire logic rxh_stat_valid,
  input wire mfmc_pkg::mfmc_rx_stat_s rxh_stat,
  input wire logic txh_valid,
  input wire logic txh_last,
  input wire logic txh_ready,
  input wire logic tx_valid,
  input wire logic tx_last
);
  import mfmc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_host_end;
    txh_valid && txh_ready && txh_last;
  endsequence
  sequence s_fcs_tail;
    (tx_valid && !tx_last)[*3] ##1 (tx_valid && tx_last);
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its read cycle");
  a_tx_next: assert property (txh_valid && txh_ready |=> tx_valid)
    else $error("taken host byte not sent");
  a_fcs_tail: assert property (s_host_end ##1 (tx_valid && !tx_last) |=> s_fcs_tail)
    else $error("check bytes malformed");
  a_ready_gap: assert property ($fell(txh_ready) |-> (!txh_ready)[*4] ##1 txh_ready)
    else $error("host ready gap wrong");
  a_tx_quiet: assert property (txh_ready && !txh_valid |=> !tx_valid)
    else $error("unrequested transmit byte");
  a_last_stat: assert property (rxh_last |-> ##[1:2] rxh_stat_valid)
    else $error("no status after last byte");
  a_stat_pulse: assert property (rxh_stat_valid |=> !rxh_stat_valid)
    else $error("status pulse too long");
  a_fcs_withheld: assert property (rxh_stat_valid && rxh_stat.vlan_stripped |-> !rxh_stat.fcs_passed)
    else $error("check bytes passed after strip");
  a_discard_cause: assert property (rxh_stat_valid && rxh_stat.discard |-> rxh_stat.error)
    else $error("discard without error");
endmodule : mfmc_props
bind mfmc_top mfmc_props u_mfmc_props (.*);

// *** mfmc_media.sv ***
// Media side model: streams frames into the slice and records what it sends.
// Assumes the bench calls send between frames; the idle gap covers flush and status.
`timescale 1ns/1ps
module mfmc_media (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_err,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic [7:0] tq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_err = 1'b0;
  end
  always @(posedge clk) if (tx_valid === 1'b1) tq.push_back(tx_data);
  task automatic send(input logic [7:0] q[$], input int bad);
    foreach (q[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_last <= (i == q.size() - 1);
      rx_err <= (i == bad);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_err <= 1'b0;
    // The idle line must not keep showing the last byte.
    rx_data <= ~rx_data;
    repeat (10) @(posedge clk);
  endtask : send
endmodule : mfmc_media

// *** mfmc_tb.sv ***
// Self-checking bench: register, receive, transmit and wake scenarios.
// Assumes the media model and the bound checker.
`timescale 1ns/1ps
module mfmc_tb;
  import mfmc_pkg::*;
  localparam logic [47:0] STA = 48'h02_11_22_33_44_55;
  localparam logic [47:0] BC = 48'hffff_ffff_ffff;
  logic clk, rst, reg_wr, reg_rd, rx_valid, rx_last, rx_err, rxh_valid, rxh_last, rxh_stat_valid;
  logic txh_valid, txh_last, txh_ready, tx_valid, tx_last, wake_req, irq;
  logic [7:0] reg_addr, rx_data, rxh_data, txh_data, tx_data;
  logic [31:0] reg_wdata, reg_rdata;
  mfmc_rx_stat_s rxh_stat;
  logic [7:0] f[$], rq[$], e[$];
  int err_total = 0;
  int num_checks = 0;
  mfmc_top u_mfmc_top (.*);
  mfmc_media u_mfmc_media (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (rxh_valid === 1'b1) rq.push_back(rxh_data);
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic cmpq(input logic [7:0] s[$]);
    chk(s.size(), e.size());
    foreach (e[i]) chk(s[i], e[i]);
  endtask : cmpq
  task automatic tally_and_finish(input bit hung);
    err_total += hung;
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] fcs(input logic [7:0] q[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? CRC_POLY : 32'h0);
    return ~c;
  endfunction : fcs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask : rdc
  task automatic tx_send(input int n, input bit wf);
    int k;
    logic [31:0] c;
    e = {};
    u_mfmc_media.tq = {};
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      e.push_back(8'h30 + i[7:0]);
      txh_valid <= 1'b1;
      txh_data <= e[i];
      txh_last <= (i == n - 1);
      k = 0;
      @(posedge clk);
      while (txh_ready !== 1'b1 && k < 20) begin
        @(posedge clk);
        k++;
      end
      if (k == 20) tally_and_finish(1'b1);
    end
    txh_valid <= 1'b0;
    txh_last <= 1'b0;
    repeat (8) @(posedge clk);
    c = fcs(e);
    for (int i = 0; i < 4 * wf; i++) e.push_back(c[i*8 +: 8]);
    cmpq(u_mfmc_media.tq);
  endtask : tx_send
  task automatic rx(input logic [47:0] d, input logic [15:0] t, input bit wk, input int n, bad, ex);
    logic [31:0] c;
    f = {};
    for (int i = 5; i >= 0; i--) f.push_back(d[i*8 +: 8]);
    for (int i = 0; i < 6; i++) f.push_back(8'h20 + i[7:0]);
    f.push_back(t[15:8]);
    f.push_back(t[7:0]);
    for (int i = 0; i < 102 * wk; i++) f.push_back(i < 6 ? 8'hff : STA[(5 - (i - 6) % 6) * 8 +: 8]);
    for (int i = 0; i < n; i++) f.push_back(i[7:0]);
    c = fcs(f);
    for (int i = 0; i < 4; i++) f.push_back(c[i*8 +: 8]);
    rq = {};
    u_mfmc_media.send(f, bad);
    case (ex)
      0: e = f[0:f.size()-5];
      1: e = f;
      2: e = {f[0:11], f[16:f.size()-5]};
      default: e = f[0:31];
    endcase
    cmpq(rq);
    chk(rxh_stat.length, e.size());
  endtask : rx
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    txh_valid = 1'b0;
    txh_data = 8'h00;
    txh_last = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(A_MODE, MODE_RESET);
    rdc(A_BUF_SIZE, {16'h0, BUF_RESET});
    rdc(8'hfc, 32'h0);
    wr(A_MODE, 32'h0077_4000);
    rdc(A_MODE, 32'h00ee_4000);
    wr(A_MODE, 32'h0044_4000);
    rdc(A_MODE, 32'h00aa_4000);
    tx_send(10, 1'b1);
    rx(STA, 16'h0800, 1'b0, 30, -1, 1);
    chk(rxh_stat[7:0], 8'h04);
    wr(A_INT_MASK, 32'h10);
    wr(A_STA_LO, STA[31:0]);
    wr(A_STA_HI, {16'h0, STA[47:32]});
    rx(BC, 16'h0800, 1'b1, 4, -1, 1);
    chk({wake_req, irq}, 2'b00);
    rx(STA, 16'h0800, 1'b1, 4, -1, 1);
    chk({wake_req, irq}, 2'b11);
    wr(A_INT_STAT, 32'h1f);
    repeat (3) @(posedge clk);
    chk({wake_req, irq}, 2'b00);
    wr(A_MODE, 32'h0041_4000);
    rx(BC, 16'h0800, 1'b1, 4, -1, 1);
    chk(wake_req, 1'b1);
    wr(A_INT_STAT, 32'h1f);
    wr(A_MODE, 32'h0900_4000);
    rx(STA, VLAN_TPID, 1'b0, 20, -1, 2);
    chk(rxh_stat[7:0], 8'h02);
    rx(STA, 16'h0800, 1'b0, 20, 3, 1);
    chk(rxh_stat[7:0], 8'h55);
    wr(A_MODE, 32'h0005_4000);
    rx(STA, 16'h0800, 1'b0, 20, 3, 1);
    chk(rxh_stat[7:0], 8'h54);
    wr(A_BUF_SIZE, 32'h20);
    rx(STA, 16'h0800, 1'b0, 40, -1, 3);
    chk(rxh_stat.overflow, 1'b1);
    wr(A_BUF_SIZE, 32'h600);
    rx(STA, 16'h0800, 1'b0, 1512, -1, 1);
    chk(rxh_stat[7:0], 8'h34);
    // Checksum insertion is switched off here: this write clears bit 19.
    wr(A_MODE, 32'h0008_4000);
    tx_send(10, 1'b0);
    tally_and_finish(1'b0);
  end
endmodule : mfmc_tb
